// [rtl/pbc_defs.svh]
// Register map, field positions, reset values and timing of the batch counter outputs
// Contract
// - Four prescales 1.0, 0.1, 0.01, 0.001; 1.0 default
// - Displayed value limited to six digits
// - Display is pulses times prescale, scale, decimal point
// - Primary scale factor defaults to 01.0000
// - Primary decimal position defaults to none
// - Secondary mode dual or batch, dual default
// - Dual: secondary follows primary events and direction
// - Dual: each count own scaling and reset
// - Batch: secondary increments on each primary auto reset
// - Secondary prescale same four values, 1.0 default
// - Secondary scale factor defaults to 01.0000
// - Secondary decimal position defaults to none
// - Two outputs: disabled, timed, latched or boundary
// - Timed: active for 0.01 to 599.99 s
// - Timed output ignores triggers while running
// - Reset cancels an active timed output
// - Latch: active until chosen until condition
// - Until reset: only panel, external or auto reset clears
// - Until set point: cleared at high point
// - Until reset position: cleared at reset position
// - Boundary: active only between low and high
// - Activation independent of count direction
// - Auto reset clears outputs, loads reset position
`ifndef PBC_DEFS_SVH
`define PBC_DEFS_SVH

// Byte offsets of the word registers
`define PBC_OFS_CTRL 7'h00
`define PBC_OFS_CFG 7'h04
`define PBC_OFS_PRI_SCALE 7'h08
`define PBC_OFS_SEC_SCALE 7'h0C
`define PBC_OFS_OUTA_CFG 7'h10
`define PBC_OFS_OUTB_CFG 7'h14
`define PBC_OFS_A_TRIG 7'h18
`define PBC_OFS_A_HIGH 7'h1C
`define PBC_OFS_B_TRIG 7'h20
`define PBC_OFS_B_HIGH 7'h24
`define PBC_OFS_A_DELAY 7'h28
`define PBC_OFS_B_DELAY 7'h2C
`define PBC_OFS_RSTPOS1 7'h30
`define PBC_OFS_RSTPOS2 7'h34
`define PBC_OFS_COUNT1 7'h38
`define PBC_OFS_COUNT2 7'h3C
`define PBC_OFS_DISP1 7'h40
`define PBC_OFS_DISP2 7'h44
`define PBC_OFS_STATUS 7'h48

// Field positions
`define PBC_CTRL_RST1 0
`define PBC_CTRL_RST2 1
`define PBC_CFG_PSC1 1:0
`define PBC_CFG_PRI_DPOS 4:2
`define PBC_CFG_BATCH 5
`define PBC_CFG_PSC2 7:6
`define PBC_CFG_SEC_DPOS 10:8
`define PBC_CFG_AUTO 12:11
`define PBC_OCFG_MODE 1:0
`define PBC_OCFG_UNTIL 3:2
`define PBC_OCFG_SRC 4

// Reset values and limits
`define PBC_CFG_RST 13'h0000
`define PBC_SCALE_RST 17'h02710
`define PBC_OCFG_RST 5'h02
`define PBC_SP_RST 32'h0000000A
`define PBC_DELAY_RST 16'h0064
`define PBC_DELAY_MAX 16'hEA5F
`define PBC_DISP_MAX 80'sd999999
`define PBC_DISP_MIN (-80'sd99999)

// Timing: delay unit is 0.01 s, clock period 5 ns
`define PBC_DELAY_UNIT_NS 10000000
`define PBC_CLK_PERIOD_NS 5

`endif

// [rtl/pbc_pkg.sv]
// Types of the batch counter outputs block
package pbc_pkg;

    typedef enum logic [1:0] {
        OM_DISABLED = 2'h0,
        OM_TIMED = 2'h1,
        OM_LATCH = 2'h2,
        OM_BOUNDARY = 2'h3
    } pbc_out_mode_t;

    typedef enum logic [1:0] {
        LU_RESET = 2'h0,
        LU_SETPOINT = 2'h1,
        LU_RSTPOS = 2'h2,
        LU_SPARE = 2'h3
    } pbc_until_t;

    typedef enum logic [1:0] {
        AR_DISABLED = 2'h0,
        AR_SETPOINT = 2'h1,
        AR_AFTER_A = 2'h2,
        AR_AFTER_B = 2'h3
    } pbc_auto_t;

    typedef enum logic [1:0] {
        OS_IDLE = 2'b01,
        OS_ACTIVE = 2'b10
    } pbc_out_state_t;

    typedef struct packed {
        logic [2:0] pls_sy;
        logic [1:0] dir_sy;
        logic [2:0] xrst_sy;
        logic waitreq;
        logic [31:0] rdata;
        logic [12:0] cfg;
        logic [1:0][16:0] scale;
        logic [1:0][4:0] ocfg;
        logic [1:0][31:0] trig;
        logic [1:0][31:0] high;
        logic [1:0][15:0] delay;
        logic [1:0][31:0] rstpos;
        logic [1:0][31:0] count;
        logic [1:0][31:0] disp;
        logic [1:0][31:0] disp_prev;
        logic [1:0] quiet;
        pbc_out_state_t [1:0] ost;
        logic [1:0][15:0] remain;
        logic [1:0][31:0] tick;
        logic [1:0] out;
        logic [1:0] timeout;
        logic auto_rst;
    } pbc_state_t;

endpackage : pbc_pkg

// [rtl/pbc_top.sv]
// Scaling, secondary count and two set point outputs with an Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
`include "pbc_defs.svh"

module pbc_top #(
    parameter int unsigned TICK_CYCLES = `PBC_DELAY_UNIT_NS / `PBC_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [6:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Count pins from the encoder or sensor
    input wire logic count_pulse,
    input wire logic count_dir,
    input wire logic ext_reset,
    // Set point outputs
    output logic out_a,
    output logic out_b
);

    pbc_pkg::pbc_state_t s;
    pbc_pkg::pbc_state_t n;

    // Scale a raw count: pulses x scale x 10^dp / (10^4 x 10^prescale), clamped to six digits
    function automatic logic signed [31:0] pbc_scale(
        input logic signed [31:0] raw,
        input logic [16:0] scl,
        input logic [1:0] psc,
        input logic [2:0] dp
    );
        logic signed [79:0] p;
        logic signed [79:0] m;
        logic signed [79:0] d;
        p = 80'(raw) * 80'($signed({1'b0, scl}));
        case (dp)
            3'h0: m = 80'sd1;
            3'h1: m = 80'sd10;
            3'h2: m = 80'sd100;
            3'h3: m = 80'sd1000;
            3'h4: m = 80'sd10000;
            default: m = 80'sd100000;
        endcase
        case (psc)
            2'h0: d = 80'sd10000;
            2'h1: d = 80'sd100000;
            2'h2: d = 80'sd1000000;
            default: d = 80'sd10000000;
        endcase
        p = (p * m) / d;
        if (p > `PBC_DISP_MAX)
            p = `PBC_DISP_MAX;
        else if (p < `PBC_DISP_MIN)
            p = `PBC_DISP_MIN;
        return 32'(p);
    endfunction : pbc_scale

    // True when the value lands on or passes a set point, in either direction
    function automatic logic pbc_reach(
        input logic signed [31:0] cur,
        input logic signed [31:0] prev,
        input logic signed [31:0] sp
    );
        return (cur == sp && prev != sp) || (prev < sp && cur > sp) || (prev > sp && cur < sp);
    endfunction : pbc_reach

    // Read value of each address
    function automatic logic [31:0] pbc_rd(input pbc_pkg::pbc_state_t r, input logic [6:0] a);
        case (a)
            `PBC_OFS_CFG: return {19'h00000, r.cfg};
            `PBC_OFS_PRI_SCALE: return {15'h0000, r.scale[0]};
            `PBC_OFS_SEC_SCALE: return {15'h0000, r.scale[1]};
            `PBC_OFS_OUTA_CFG: return {27'h0000000, r.ocfg[0]};
            `PBC_OFS_OUTB_CFG: return {27'h0000000, r.ocfg[1]};
            `PBC_OFS_A_TRIG: return r.trig[0];
            `PBC_OFS_A_HIGH: return r.high[0];
            `PBC_OFS_B_TRIG: return r.trig[1];
            `PBC_OFS_B_HIGH: return r.high[1];
            `PBC_OFS_A_DELAY: return {16'h0000, r.delay[0]};
            `PBC_OFS_B_DELAY: return {16'h0000, r.delay[1]};
            `PBC_OFS_RSTPOS1: return r.rstpos[0];
            `PBC_OFS_RSTPOS2: return r.rstpos[1];
            `PBC_OFS_COUNT1: return r.count[0];
            `PBC_OFS_COUNT2: return r.count[1];
            `PBC_OFS_DISP1: return r.disp[0];
            `PBC_OFS_DISP2: return r.disp[1];
            `PBC_OFS_STATUS: return {28'h0000000, r.ost[1] == pbc_pkg::OS_ACTIVE,
                r.ost[0] == pbc_pkg::OS_ACTIVE, r.out};
            default: return 32'h00000000;
        endcase
    endfunction : pbc_rd

    // Next state of the whole block
    always_comb
    begin
        logic [31:0] mask;
        logic [31:0] wv;
        logic wr_go;
        logic cnt_ev;
        logic dn;
        logic rst1;
        logic rst2;
        logic src;
        logic hit;
        logic hit_a;
        logic hit_hi;
        logic at_rp;
        logic signed [31:0] cur;
        logic signed [31:0] step;
        mask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
        wv = (pbc_rd(s, address) & ~mask) | (writedata & mask);
        wr_go = write && !s.waitreq;
        cnt_ev = s.pls_sy[1] && !s.pls_sy[2];
        dn = s.dir_sy[1];
        hit_a = 1'b0;
        src = 1'b0;
        hit = 1'b0;
        hit_hi = 1'b0;
        at_rp = 1'b0;
        cur = 32'sd0;
        step = 32'sd0;
        n = s;

        // Pin synchronisers; edge detect reads only the second stage onward
        n.pls_sy = {s.pls_sy[1:0], count_pulse};
        n.dir_sy = {s.dir_sy[0], count_dir};
        n.xrst_sy = {s.xrst_sy[1:0], ext_reset};

        // Bus slave: one wait cycle, then the answer
        n.waitreq = !((read || write) && s.waitreq);
        if (read && s.waitreq)
            n.rdata = pbc_rd(s, address);
        rst1 = 1'b0;
        rst2 = 1'b0;
        if (wr_go)
        begin
            case (address)
                `PBC_OFS_CTRL:
                begin
                    rst1 = writedata[`PBC_CTRL_RST1] && byteenable[0];
                    rst2 = writedata[`PBC_CTRL_RST2] && byteenable[0];
                end
                `PBC_OFS_CFG: n.cfg = wv[12:0];
                `PBC_OFS_PRI_SCALE: n.scale[0] = wv[16:0];
                `PBC_OFS_SEC_SCALE: n.scale[1] = wv[16:0];
                `PBC_OFS_OUTA_CFG: n.ocfg[0] = wv[4:0];
                `PBC_OFS_OUTB_CFG: n.ocfg[1] = wv[4:0];
                `PBC_OFS_A_TRIG: n.trig[0] = wv;
                `PBC_OFS_A_HIGH: n.high[0] = wv;
                `PBC_OFS_B_TRIG: n.trig[1] = wv;
                `PBC_OFS_B_HIGH: n.high[1] = wv;
                `PBC_OFS_A_DELAY: n.delay[0] = (wv[15:0] > `PBC_DELAY_MAX)
                    ? `PBC_DELAY_MAX : wv[15:0];
                `PBC_OFS_B_DELAY: n.delay[1] = (wv[15:0] > `PBC_DELAY_MAX)
                    ? `PBC_DELAY_MAX : wv[15:0];
                `PBC_OFS_RSTPOS1: n.rstpos[0] = wv;
                `PBC_OFS_RSTPOS2: n.rstpos[1] = wv;
                default: ;
            endcase
        end
        rst1 = rst1 || (s.xrst_sy[1] && !s.xrst_sy[2]);
        rst2 = rst2 || (s.xrst_sy[1] && !s.xrst_sy[2]);

        // Scaled display values, each with its own settings
        n.disp[0] = pbc_scale(s.count[0], s.scale[0], s.cfg[`PBC_CFG_PSC1],
            s.cfg[`PBC_CFG_PRI_DPOS]);
        n.disp[1] = pbc_scale(s.count[1], s.scale[1], s.cfg[`PBC_CFG_PSC2],
            s.cfg[`PBC_CFG_SEC_DPOS]);
        n.disp_prev = s.disp;
        n.quiet = {1'b0, s.quiet[1]};
        n.timeout = 2'b00;

        // Output channels
        for (int i = 0; i < 2; i++)
        begin
            src = s.ocfg[i][`PBC_OCFG_SRC];
            cur = s.disp[src];
            hit = pbc_reach(cur, s.disp_prev[src], s.trig[i]) && s.quiet == 2'h0;
            hit_hi = pbc_reach(cur, s.disp_prev[src], s.high[i]) && s.quiet == 2'h0;
            at_rp = s.count[src] == s.rstpos[src];
            if (i == 0)
                hit_a = hit;
            case (pbc_pkg::pbc_out_mode_t'(s.ocfg[i][`PBC_OCFG_MODE]))
                pbc_pkg::OM_DISABLED:
                    n.ost[i] = pbc_pkg::OS_IDLE;
                pbc_pkg::OM_TIMED:
                begin
                    if (s.ost[i] == pbc_pkg::OS_IDLE && hit)
                    begin
                        n.ost[i] = pbc_pkg::OS_ACTIVE;
                        n.remain[i] = (s.delay[i] == 16'h0000) ? 16'h0001 : s.delay[i];
                        n.tick[i] = 32'h00000000;
                    end
                    else if (s.ost[i] == pbc_pkg::OS_ACTIVE)
                    begin
                        n.tick[i] = s.tick[i] + 32'h00000001;
                        if (s.tick[i] == 32'(TICK_CYCLES - 1))
                        begin
                            n.tick[i] = 32'h00000000;
                            n.remain[i] = s.remain[i] - 16'h0001;
                            if (s.remain[i] <= 16'h0001)
                            begin
                                n.ost[i] = pbc_pkg::OS_IDLE;
                                n.timeout[i] = 1'b1;
                            end
                        end
                    end
                end
                pbc_pkg::OM_LATCH:
                begin
                    if (s.ost[i] == pbc_pkg::OS_IDLE && hit)
                        n.ost[i] = pbc_pkg::OS_ACTIVE;
                    else if (s.ost[i] == pbc_pkg::OS_ACTIVE)
                    begin
                        case (pbc_pkg::pbc_until_t'(s.ocfg[i][`PBC_OCFG_UNTIL]))
                            pbc_pkg::LU_SETPOINT:
                                if (hit_hi)
                                    n.ost[i] = pbc_pkg::OS_IDLE;
                            pbc_pkg::LU_RSTPOS:
                                if (at_rp && s.quiet == 2'h0)
                                    n.ost[i] = pbc_pkg::OS_IDLE;
                            default: ;
                        endcase
                    end
                end
                pbc_pkg::OM_BOUNDARY:
                    n.ost[i] = ($signed(cur) >= $signed(s.trig[i])
                        && $signed(cur) <= $signed(s.high[i]))
                        ? pbc_pkg::OS_ACTIVE : pbc_pkg::OS_IDLE;
                default: n.ost[i] = pbc_pkg::OS_IDLE;
            endcase
        end

        // Automatic reset source
        case (pbc_pkg::pbc_auto_t'(s.cfg[`PBC_CFG_AUTO]))
            pbc_pkg::AR_SETPOINT: n.auto_rst = hit_a;
            pbc_pkg::AR_AFTER_A: n.auto_rst = n.timeout[0];
            pbc_pkg::AR_AFTER_B: n.auto_rst = n.timeout[1];
            default: n.auto_rst = 1'b0;
        endcase

        // Counting, with resets taking priority over pulses
        step = dn ? -32'sd1 : 32'sd1;
        if (cnt_ev)
        begin
            n.count[0] = s.count[0] + step;
            if (!s.cfg[`PBC_CFG_BATCH])
                n.count[1] = s.count[1] + step;
        end
        if (rst1 || n.auto_rst)
        begin
            n.count[0] = s.rstpos[0];
            n.ost = {pbc_pkg::OS_IDLE, pbc_pkg::OS_IDLE};
            n.remain = '0;
            n.tick = '0;
            n.quiet = 2'h3;
        end
        if (n.auto_rst && s.cfg[`PBC_CFG_BATCH])
            n.count[1] = s.count[1] + 32'h00000001;
        if (rst2)
            n.count[1] = s.rstpos[1];
        for (int i = 0; i < 2; i++)
            n.out[i] = n.ost[i] == pbc_pkg::OS_ACTIVE;
    end

    // State register with synchronous reset to the defaults
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s <= '0;
            s.waitreq <= 1'b1;
            s.cfg <= `PBC_CFG_RST;
            s.scale <= {`PBC_SCALE_RST, `PBC_SCALE_RST};
            s.ocfg <= {`PBC_OCFG_RST, `PBC_OCFG_RST};
            s.trig <= {`PBC_SP_RST, `PBC_SP_RST};
            s.high <= {`PBC_SP_RST, `PBC_SP_RST};
            s.delay <= {`PBC_DELAY_RST, `PBC_DELAY_RST};
            s.ost <= {pbc_pkg::OS_IDLE, pbc_pkg::OS_IDLE};
        end
        else
            s <= n;
    end

    // Outputs straight from the state register
    assign readdata = s.rdata;
    assign waitrequest = s.waitreq;
    assign out_a = s.out[0];
    assign out_b = s.out[1];

    // Checks on the block's own behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_defaults;
        $past(rst) |-> s.cfg == `PBC_CFG_RST && s.scale[0] == `PBC_SCALE_RST
            && s.scale[1] == `PBC_SCALE_RST;
    endproperty
    a_defaults: assert property (p_defaults) else $error("defaults wrong after reset");

    property p_six_digits;
        $signed(s.disp[0]) <= 32'sd999999 && $signed(s.disp[0]) >= -32'sd99999;
    endproperty
    a_six_digits: assert property (p_six_digits) else $error("display beyond six digits");

    property p_disabled_low;
        s.ocfg[0][`PBC_OCFG_MODE] == 2'h0 ##1 s.ocfg[0][`PBC_OCFG_MODE] == 2'h0 |-> !out_a;
    endproperty
    a_disabled_low: assert property (p_disabled_low) else $error("disabled output active");

    property p_boundary;
        s.ocfg[1][`PBC_OCFG_MODE] == 2'h3 && !n.auto_rst && !(s.xrst_sy[1] && !s.xrst_sy[2])
            && !(write && !s.waitreq)
        |=> out_b == ($signed($past(s.disp[s.ocfg[1][4]])) >= $signed($past(s.trig[1]))
            && $signed($past(s.disp[s.ocfg[1][4]])) <= $signed($past(s.high[1])));
    endproperty
    a_boundary: assert property (p_boundary) else $error("boundary output wrong");

    property p_auto_reset;
        n.auto_rst |=> !out_a && !out_b && s.count[0] == $past(s.rstpos[0]);
    endproperty
    a_auto_reset: assert property (p_auto_reset) else $error("auto reset did not clear");

    property p_batch;
        n.auto_rst && s.cfg[`PBC_CFG_BATCH] && !(write && !s.waitreq)
            && !(s.xrst_sy[1] && !s.xrst_sy[2]) |=> s.count[1] == $past(s.count[1]) + 32'h1;
    endproperty
    a_batch: assert property (p_batch) else $error("batch count not advanced");

    property p_dual_follow;
        s.pls_sy[1] && !s.pls_sy[2] && !s.cfg[`PBC_CFG_BATCH] && !(write && !s.waitreq)
            && !(s.xrst_sy[1] && !s.xrst_sy[2]) && !n.auto_rst
        |=> s.count[1] - $past(s.count[1]) == s.count[0] - $past(s.count[0]);
    endproperty
    a_dual_follow: assert property (p_dual_follow) else $error("secondary did not follow");

    property p_no_retrigger;
        s.ost[0] == pbc_pkg::OS_ACTIVE && s.ocfg[0][1:0] == 2'h1 && !n.auto_rst
            && !(s.xrst_sy[1] && !s.xrst_sy[2]) && !(write && !s.waitreq)
        |=> s.remain[0] <= $past(s.remain[0]);
    endproperty
    a_no_retrigger: assert property (p_no_retrigger) else $error("timed output retriggered");

    property p_ext_cancel;
        s.xrst_sy[1] && !s.xrst_sy[2] |=> !out_a && !out_b ##1 s.quiet != 2'h3;
    endproperty
    a_ext_cancel: assert property (p_ext_cancel) else $error("reset left an output on");

    // A latched output with the reset choice holds while no reset of any kind arrives
    property p_latch_hold;
        s.ost[0] == pbc_pkg::OS_ACTIVE && s.ocfg[0][3:0] == 4'h2 && !n.auto_rst
            && !(s.xrst_sy[1] && !s.xrst_sy[2]) && !(write && !s.waitreq)
        |=> out_a;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched output dropped");

    // Latched until reset position: the raw source count at that position releases it
    property p_rp_release;
        s.ost[0] == pbc_pkg::OS_ACTIVE && s.ocfg[0][3:0] == 4'hA && s.quiet == 2'h0
            && s.count[s.ocfg[0][4]] == s.rstpos[s.ocfg[0][4]] |=> !out_a;
    endproperty
    a_rp_release: assert property (p_rp_release) else $error("output not released");

    property p_bus_answer;
        (read || write) && waitrequest |=> !waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

    c_timed_run: cover property (out_a && s.ocfg[0][1:0] == 2'h1 ##1 !out_a);
    c_latch_hold: cover property (out_b && s.ocfg[1][1:0] == 2'h2);
    c_batch_step: cover property (n.auto_rst && s.cfg[`PBC_CFG_BATCH]);
    c_boundary_on: cover property (!out_b ##1 out_b && s.ocfg[1][1:0] == 2'h3);

endmodule : pbc_top
`default_nettype wire

// [tb/pbc_pulse_src.sv]
// Behavioural pulse encoder that drives the count pins
`timescale 1ns/1ps
`default_nettype none

module pbc_pulse_src (
    // Clock
    input wire logic ref_clk,
    // Count pins
    output logic count_pulse,
    output logic count_dir,
    output logic ext_reset
);
    // Pins idle low from time zero
    initial
    begin
        count_pulse = 1'b0;
        count_dir = 1'b0;
        ext_reset = 1'b0;
    end

    // Pulses with direction settled first; gap sets prompt or slow pacing
    task send(input int n, input logic dn, input int gap);
        for (int i = 0; i < n; i++)
        begin
            @(posedge ref_clk);
            count_dir <= dn;
            repeat (2) @(posedge ref_clk);
            count_pulse <= 1'b1;
            repeat (4) @(posedge ref_clk);
            count_pulse <= 1'b0;
            repeat (gap) @(posedge ref_clk);
        end
    endtask : send

    // External reset pulse, long enough to pass the synchroniser
    task kick();
        @(posedge ref_clk);
        ext_reset <= 1'b1;
        repeat (4) @(posedge ref_clk);
        ext_reset <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask : kick
endmodule : pbc_pulse_src

`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench of the batch counter outputs
`timescale 1ns/1ps
`default_nettype none
`include "pbc_defs.svh"

module tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] address = 7'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest, count_pulse, count_dir, ext_reset, out_a, out_b;
    logic [31:0] exp_q[$];
    logic [31:0] sc;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    int hi = 0;
    int n, d1, d2;

    // Clock at 200 MHz
    always #2.5 ref_clk = ~ref_clk;

    pbc_top #(.TICK_CYCLES(4)) uut (
        .ref_clk(ref_clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hF),
        .readdata(readdata), .waitrequest(waitrequest), .count_pulse(count_pulse),
        .count_dir(count_dir), .ext_reset(ext_reset), .out_a(out_a), .out_b(out_b)
    );

    pbc_pulse_src src (
        .ref_clk(ref_clk), .count_pulse(count_pulse), .count_dir(count_dir),
        .ext_reset(ext_reset)
    );

    // Comparison and report
    task cmp(input logic [31:0] g, input logic [31:0] e);
        check_count = check_count + 1;
        if (g !== e)
        begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp

    task chk(input logic [31:0] g, input logic [31:0] e);
        @(negedge ref_clk);
        cmp(g, e);
    endtask : chk

    task give_verdict();
        if (exp_q.size() != 0)
            n_mismatch = n_mismatch + 1;
        if (n_mismatch == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    // Avalon-MM master: hold request until waitrequest is sampled low
    task bus(input logic is_wr, input logic [6:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        address <= a;
        writedata <= d;
        write <= is_wr;
        read <= ~is_wr;
        @(negedge ref_clk);
        while (waitrequest !== 1'b0)
            @(negedge ref_clk);
        @(posedge ref_clk);
        write <= 1'b0;
        read <= 1'b0;
    endtask : bus

    task wr(input logic [6:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task rd(input logic [6:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd

    // Expected display: scaled, truncated and clamped to six digits
    function automatic logic [31:0] dexp(longint c, longint s, int dp, int psc);
        longint v;
        v = c * s;
        for (int i = 0; i < dp; i++)
            v = v * 10;
        for (int i = 0; i < 4 + psc; i++)
            v = v / 10;
        if (v > 999999)
            v = 999999;
        return v[31:0];
    endfunction : dexp

    // Read watcher takes the oldest note when read data stand
    always @(negedge ref_clk)
        if (read === 1'b1 && waitrequest === 1'b0)
            cmp(readdata, exp_q.pop_front());

    // Cycle ceiling and timed output high-time counter
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (out_a === 1'b1)
            hi <= hi + 1;
        if (cyc == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            give_verdict();
        end
    end

    // Main sequence
    initial
    begin
        n = $urandom(32'h177E);
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        rd(`PBC_OFS_CFG, 32'h0);
        rd(`PBC_OFS_PRI_SCALE, 32'h2710);
        rd(`PBC_OFS_SEC_SCALE, 32'h2710);
        rd(`PBC_OFS_OUTA_CFG, 32'h2);
        rd(7'h7C, 32'h0);
        // Latch until reset; dual count follows
        wr(`PBC_OFS_A_TRIG, 32'h3);
        src.send(3, 1'b0, 4);
        chk(out_a, 32'h1);
        rd(`PBC_OFS_COUNT2, 32'h3);
        wr(`PBC_OFS_CTRL, 32'h2);
        rd(`PBC_OFS_COUNT2, 32'h0);
        chk(out_a, 32'h1);
        src.kick();
        chk(out_a, 32'h0);
        // Trigger reached counting down
        wr(`PBC_OFS_A_TRIG, 32'hFFFFFFFE);
        src.send(2, 1'b1, 9);
        chk(out_a, 32'h1);
        rd(`PBC_OFS_DISP1, 32'hFFFFFFFE);
        // Every prescale with random scale and decimal positions
        for (int k = 0; k < 4; k++)
        begin
            sc = $urandom_range(32'h1FFFF, 32'h1);
            d1 = $urandom_range(5, 0);
            d2 = $urandom_range(5, 0);
            n = $urandom_range(5, 1);
            wr(`PBC_OFS_CFG, (d2 << 8) | ((3 - k) << 6) | (d1 << 2) | k);
            wr(`PBC_OFS_PRI_SCALE, sc);
            src.kick();
            src.send(n, 1'b0, 4);
            rd(`PBC_OFS_DISP1, dexp(n, sc, d1, k));
            rd(`PBC_OFS_DISP2, dexp(n, 32'h2710, d2, 3 - k));
        end
        // Timed output, retriggered while running; its time-out auto resets count 1
        wr(`PBC_OFS_CFG, 32'h1000);
        wr(`PBC_OFS_PRI_SCALE, 32'h2710);
        wr(`PBC_OFS_OUTA_CFG, 32'h1);
        wr(`PBC_OFS_A_DELAY, 32'h14);
        wr(`PBC_OFS_A_TRIG, 32'h1);
        src.kick();
        hi <= 0;
        src.send(1, 1'b0, 4);
        src.send(1, 1'b1, 4);
        src.send(1, 1'b0, 4);
        repeat (120) @(posedge ref_clk);
        chk(hi == 80 || hi == 81, 32'h1);
        rd(`PBC_OFS_COUNT1, 32'h0);
        src.send(1, 1'b0, 4);
        chk(out_a, 32'h1);
        wr(`PBC_OFS_CTRL, 32'h1);
        repeat (3) @(posedge ref_clk);
        chk(out_a, 32'h0);
        // Boundary window; second output disabled
        wr(`PBC_OFS_OUTA_CFG, 32'h3);
        wr(`PBC_OFS_OUTB_CFG, 32'h0);
        wr(`PBC_OFS_B_TRIG, 32'h2);
        wr(`PBC_OFS_A_TRIG, 32'h2);
        wr(`PBC_OFS_A_HIGH, 32'h3);
        src.kick();
        for (int i = 1; i < 5; i++)
        begin
            src.send(1, 1'b0, 4);
            chk(out_a, i >= 2 && i <= 3);
            chk(out_b, 32'h0);
        end
        // Latch until reset position on A; latch until high point on B from count 2
        wr(`PBC_OFS_OUTA_CFG, 32'hA);
        wr(`PBC_OFS_OUTB_CFG, 32'h16);
        wr(`PBC_OFS_B_HIGH, 32'h4);
        src.kick();
        src.send(2, 1'b0, 4);
        rd(`PBC_OFS_STATUS, 32'hF);
        src.send(2, 1'b0, 4);
        chk(out_b, 32'h0);
        chk(out_a, 32'h1);
        src.send(4, 1'b1, 4);
        chk(out_a, 32'h0);
        chk(out_b, 32'h1);
        // Batch count of auto resets to the reset position
        wr(`PBC_OFS_OUTA_CFG, 32'h2);
        src.kick();
        wr(`PBC_OFS_RSTPOS1, 32'hFFFFFFFF);
        wr(`PBC_OFS_CFG, 32'h820);
        for (int k = 1; k < 3; k++)
        begin
            src.send(k + 1, 1'b0, 4);
            rd(`PBC_OFS_COUNT1, 32'hFFFFFFFF);
            rd(`PBC_OFS_COUNT2, k);
            chk(out_a, 32'h0);
        end
        give_verdict();
    end
endmodule : tb_top

`default_nettype wire
